// file: hdl/sasp_pkg.sv
// constants and types shared by the converter sequencer
package sasp_pkg;
    // register byte addresses on the internal bus
    localparam logic [15:0] ADDR_RESULT = 16'hFF08;
    localparam logic [15:0] ADDR_MODE   = 16'hFF28;
    localparam logic [15:0] ADDR_CHAN   = 16'hFF29;
    localparam logic [15:0] ADDR_PFM    = 16'hFF2A;
    localparam logic [15:0] ADDR_PFT    = 16'hFF2B;

    // mode register layout
    localparam int         MODE_RUN_BIT   = 7;
    localparam int         MODE_TIME_LSB  = 3;
    localparam int         MODE_BOOST_BIT = 0;
    localparam logic [7:0] MODE_WMASK     = 8'hB9;
    localparam logic [7:0] MODE_RESET     = 8'h00;

    // channel and power-fail register layout
    localparam int         CHAN_W       = 3;
    localparam int         PFM_EN_BIT   = 7;
    localparam int         PFM_POL_BIT  = 6;
    localparam logic [7:0] REG8_RESET   = 8'h00;

    // conversion geometry
    localparam int RES_BITS       = 10;
    localparam int RESULT_PAD     = 6;
    localparam int CMP_BITS       = 8;
    localparam int STEPS_PER_CONV = 12;
    localparam int SAMPLE_STEPS   = 2;
    localparam int CNT_W          = 6;
    localparam int STEP_W         = 5;

    // conversion-time codes and their lengths in main-clock cycles
    localparam logic [2:0] TC_288 = 3'h0;
    localparam logic [2:0] TC_240 = 3'h1;
    localparam logic [2:0] TC_192 = 3'h2;
    localparam logic [2:0] TC_144 = 3'h4;
    localparam logic [2:0] TC_120 = 3'h5;
    localparam logic [2:0] TC_96  = 3'h6;
    localparam int CONV_CYC_288 = 288;
    localparam int CONV_CYC_240 = 240;
    localparam int CONV_CYC_192 = 192;
    localparam int CONV_CYC_144 = 144;
    localparam int CONV_CYC_120 = 120;
    localparam int CONV_CYC_96  = 96;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV} sasp_state_e;
endpackage : sasp_pkg

// file: hdl/sasp_sync.sv
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module sasp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sasp_sync_s;

    sasp_sync_s st_reg;
    sasp_sync_s st_next;

    // first stage feeds only the second stage
    always_comb
    begin
        st_next.meta   = async_in;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign sync_out = st_reg.stable;
endmodule : sasp_sync

// file: hdl/sasp_adc.sv
// successive-approximation converter sequencer with power-fail compare
// Functional notes
// - pick one of eight inputs and produce a 10-bit result
// - while run is set, convert back to back on the selected channel
// - compare disabled: raise done interrupt after every conversion
// - compare enabled: interrupt only when the chosen threshold condition holds
// - unselected analog pins stay usable as digital inputs
// - sample selected input at conversion start, hold for whole conversion
// - resolve bits MSB first, then copy to result register
// - result reloaded each conversion, 10 bits left-justified, low 6 zero
// - mode bit 7 is run: zero stops, one converts continuously
// - time field bits 5..3 picks 288/240/192/144/120/96 cycles
// - mode bit 0 enables the boost reference generator
// - run/reference decode: stop, waiting, convert with or without reference
// - mode write inserts bus wait; no write on subsystem clock only
// - channel register low three bits select input 0..7
// - power-fail bit 7 enables compare, bit 6 picks polarity
// - 8-bit threshold compared against upper eight result bits
// - trial bit kept when input at or above tap, else cleared
`timescale 1ns/1ns
module sasp_adc
    import sasp_pkg::*;
#(
    parameter int NUM_CH = 8
) (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic [15:0]        bus_addr,
    input  wire logic               bus_wr,
    input  wire logic               bus_rd,
    input  wire logic [7:0]         bus_wdata,
    output logic      [15:0]        bus_rdata,
    output logic                    bus_wait,
    input  wire logic               cmp_ge,
    output logic      [RES_BITS-1:0] tap_code,
    output logic      [CHAN_W-1:0]  analog_mux_sel,
    output logic                    sample_hold,
    output logic                    reference_boost_enable,
    output logic                    comparator_enable,
    output logic      [NUM_CH-1:0]  digital_in_enable,
    output logic                    conversion_done_irq
);
    typedef struct packed {
        sasp_state_e          state;
        logic [7:0]           mode_reg;
        logic [CHAN_W-1:0]    chan_reg;
        logic [1:0]           pfm_reg;
        logic [7:0]           pft_reg;
        logic [RES_BITS-1:0]  sar_reg;
        logic [3:0]           bit_idx;
        logic [CNT_W-1:0]     cnt;
        logic [STEP_W-1:0]    step_len;
        logic [RES_BITS-1:0]  result_reg;
        logic                 done;
        logic                 irq;
        logic                 sample;
        logic [NUM_CH-1:0]    port_en;
        logic [15:0]          rdata;
        logic                 wait_pulse;
    } sasp_adc_s;

    sasp_adc_s st_reg;
    sasp_adc_s st_next;
    logic      cmp_ge_sync;

    // comparator output is asynchronous to clk
    sasp_sync #(.WIDTH(1)) u_cmp_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (cmp_ge),
        .sync_out (cmp_ge_sync)
    );

    // cycles per step; illegal codes fall back to the slowest setting
    function automatic logic [STEP_W-1:0] step_of(input logic [2:0] code);
        logic [STEP_W-1:0] s;
        unique case (code)
            TC_240:  s = STEP_W'(CONV_CYC_240 / STEPS_PER_CONV);
            TC_192:  s = STEP_W'(CONV_CYC_192 / STEPS_PER_CONV);
            TC_144:  s = STEP_W'(CONV_CYC_144 / STEPS_PER_CONV);
            TC_120:  s = STEP_W'(CONV_CYC_120 / STEPS_PER_CONV);
            TC_96:   s = STEP_W'(CONV_CYC_96 / STEPS_PER_CONV);
            default: s = STEP_W'(CONV_CYC_288 / STEPS_PER_CONV);
        endcase
        return s;
    endfunction : step_of

    logic                run;
    logic [RES_BITS-1:0] trial_bit;
    logic [RES_BITS-1:0] decided;
    logic                ge_thr;
    logic                irq_cond;

    // decision of the current trial and threshold compare on it
    always_comb
    begin
        run       = st_reg.mode_reg[MODE_RUN_BIT];
        trial_bit = RES_BITS'(1) << st_reg.bit_idx;
        // keep the trial bit only when input is at or above the tap
        decided   = cmp_ge_sync ? st_reg.sar_reg : (st_reg.sar_reg & ~trial_bit);
        ge_thr    = decided[RES_BITS-1 -: CMP_BITS] >= st_reg.pft_reg;
        if (!st_reg.pfm_reg[1])
            irq_cond = 1'b1;
        else
            irq_cond = st_reg.pfm_reg[0] ? !ge_thr : ge_thr;
    end

    // next-state logic for sequencer and register file
    always_comb
    begin
        st_next            = st_reg;
        st_next.done       = 1'b0;
        st_next.irq        = 1'b0;
        st_next.wait_pulse = 1'b0;
        st_next.rdata      = 16'h0000;

        // register writes; each write to these registers costs one wait
        if (bus_wr)
        begin
            unique case (bus_addr)
                ADDR_MODE:
                begin
                    st_next.mode_reg   = bus_wdata & MODE_WMASK;
                    st_next.wait_pulse = 1'b1;
                end
                ADDR_CHAN:
                begin
                    st_next.chan_reg   = bus_wdata[CHAN_W-1:0];
                    st_next.wait_pulse = 1'b1;
                end
                ADDR_PFM:
                begin
                    st_next.pfm_reg    = {bus_wdata[PFM_EN_BIT], bus_wdata[PFM_POL_BIT]};
                    st_next.wait_pulse = 1'b1;
                end
                ADDR_PFT:
                begin
                    st_next.pft_reg    = bus_wdata;
                    st_next.wait_pulse = 1'b1;
                end
                default: ;
            endcase
        end

        // register reads; unmapped addresses return zero
        if (bus_rd)
        begin
            unique case (bus_addr)
                ADDR_RESULT:
                begin
                    st_next.rdata      = {st_reg.result_reg, RESULT_PAD'(0)};
                    st_next.wait_pulse = 1'b1;
                end
                ADDR_MODE: st_next.rdata = {8'h00, st_reg.mode_reg};
                ADDR_CHAN: st_next.rdata = {13'h0000, st_reg.chan_reg};
                ADDR_PFM:  st_next.rdata = {8'h00, st_reg.pfm_reg, 6'h00};
                ADDR_PFT:  st_next.rdata = {8'h00, st_reg.pft_reg};
                default:   st_next.rdata = 16'h0000;
            endcase
        end

        // sequencer: sample phase, ten compare steps, then restart
        unique case (st_reg.state)
            ST_IDLE:
            begin
                st_next.sample = 1'b0;
                if (run)
                begin
                    st_next.step_len = step_of(st_reg.mode_reg[MODE_TIME_LSB +: 3]);
                    st_next.cnt      = CNT_W'({step_of(st_reg.mode_reg[MODE_TIME_LSB +: 3]),
                                               1'b0}) - CNT_W'(1);
                    st_next.sample   = 1'b1;
                    st_next.state    = ST_SAMPLE;
                end
            end
            ST_SAMPLE:
            begin
                st_next.cnt = st_reg.cnt - CNT_W'(1);
                if (!run)
                begin
                    st_next.sample = 1'b0;
                    st_next.state  = ST_IDLE;
                end
                else if (st_reg.cnt == '0)
                begin
                    // hold from here to the end of the conversion
                    st_next.sample  = 1'b0;
                    st_next.sar_reg = RES_BITS'(1) << (RES_BITS - 1);
                    st_next.bit_idx = 4'(RES_BITS - 1);
                    st_next.cnt     = CNT_W'(st_reg.step_len) - CNT_W'(1);
                    st_next.state   = ST_CONV;
                end
            end
            ST_CONV:
            begin
                st_next.cnt = st_reg.cnt - CNT_W'(1);
                if (!run)
                    st_next.state = ST_IDLE;
                else if (st_reg.cnt == '0)
                begin
                    if (st_reg.bit_idx == 4'h0)
                    begin
                        st_next.sar_reg    = decided;
                        st_next.result_reg = decided;
                        st_next.done       = 1'b1;
                        st_next.irq        = irq_cond;
                        st_next.sample     = 1'b1;
                        st_next.cnt        = CNT_W'({st_reg.step_len, 1'b0}) - CNT_W'(1);
                        st_next.state      = ST_SAMPLE;
                    end
                    else
                    begin
                        // next lower trial bit set, previous decided
                        st_next.sar_reg = decided | (trial_bit >> 1);
                        st_next.bit_idx = st_reg.bit_idx - 4'h1;
                        st_next.cnt     = CNT_W'(st_reg.step_len) - CNT_W'(1);
                    end
                end
            end
        endcase

        // only the selected channel is taken from the digital port
        st_next.port_en = ~(NUM_CH'(1) << st_next.chan_reg);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg          <= '0;
            st_reg.state    <= ST_IDLE;
            st_reg.mode_reg <= MODE_RESET;
            st_reg.pft_reg  <= REG8_RESET;
            st_reg.port_en  <= ~NUM_CH'(1);
        end
        else
            st_reg <= st_next;
    end

    // every output is a register field
    assign bus_rdata              = st_reg.rdata;
    assign bus_wait               = st_reg.wait_pulse;
    assign tap_code               = st_reg.sar_reg;
    assign analog_mux_sel         = st_reg.chan_reg;
    assign sample_hold            = st_reg.sample;
    assign reference_boost_enable = st_reg.mode_reg[MODE_BOOST_BIT];
    assign comparator_enable      = st_reg.mode_reg[MODE_RUN_BIT];
    assign digital_in_enable      = st_reg.port_en;
    assign conversion_done_irq    = st_reg.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_irq_plain;
        st_reg.done && !st_reg.pfm_reg[1] |-> conversion_done_irq;
    endproperty
    a_irq_plain: assert property (p_irq_plain) else $error("missing done interrupt");

    property p_irq_pf;
        st_reg.done && st_reg.pfm_reg[1] |-> conversion_done_irq ==
            (st_reg.pfm_reg[0] ? (st_reg.result_reg[9:2] < st_reg.pft_reg)
                               : (st_reg.result_reg[9:2] >= st_reg.pft_reg));
    endproperty
    a_irq_pf: assert property (p_irq_pf) else $error("threshold interrupt wrong");

    property p_restart;
        st_reg.done |-> st_reg.state == ST_SAMPLE && sample_hold;
    endproperty
    a_restart: assert property (p_restart) else $error("no back to back restart");

    property p_stop;
        !st_reg.mode_reg[MODE_RUN_BIT] |=> st_reg.state == ST_IDLE && !st_reg.done;
    endproperty
    a_stop: assert property (p_stop) else $error("conversion did not stop");

    property p_sample_hold;
        // a stop written early in the sample phase may end it legally
        $rose(sample_hold) && run |-> (sample_hold || st_reg.state == ST_IDLE)[*8];
    endproperty
    a_sample_hold: assert property (p_sample_hold) else $error("sample phase too short");

    property p_hold_conv;
        st_reg.state == ST_CONV |-> !sample_hold;
    endproperty
    a_hold_conv: assert property (p_hold_conv) else $error("sample during conversion");

    property p_msb_first;
        st_reg.state == ST_SAMPLE && st_next.state == ST_CONV |=>
            tap_code == 10'h200 && st_reg.bit_idx == 4'h9;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb not tried first");

    property p_mode_wait;
        bus_wr && bus_addr == ADDR_MODE |=> bus_wait ##1 !bus_wait;
    endproperty
    a_mode_wait: assert property (p_mode_wait) else $error("mode write without wait");

    property p_chan_sel;
        bus_wr && bus_addr == ADDR_CHAN |=> analog_mux_sel == $past(bus_wdata[2:0])
            && !digital_in_enable[analog_mux_sel];
    endproperty
    a_chan_sel: assert property (p_chan_sel) else $error("channel select not taken");
endmodule : sasp_adc

// file: bench/sasp_analog_model.sv
// behavioural analog front end: channel levels, sample-and-hold and comparator
`timescale 1ns/1ns
module sasp_analog_model
    import sasp_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic [8*RES_BITS-1:0] ch_level,
    input  wire logic [CHAN_W-1:0]     analog_mux_sel,
    input  wire logic                  sample_hold,
    input  wire logic [RES_BITS-1:0]   tap_code,
    output logic                       cmp_ge
);
    logic [RES_BITS-1:0] held_level = '0;

    // follow the selected level while sampling, freeze it while holding
    always_ff @(posedge clk)
    begin
        if (sample_hold)
        begin
            held_level <= ch_level[analog_mux_sel*RES_BITS +: RES_BITS];
        end
    end

    // ideal comparator, no offset; the design must cope with its async edge
    assign cmp_ge = (held_level >= tap_code);
endmodule : sasp_analog_model

// file: bench/sasp_adc_tb.sv
// self-checking testbench for the converter sequencer
`timescale 1ns/1ns
module sasp_adc_tb
    import sasp_pkg::*;
();
    logic                  clk = 1'b0;
    logic                  srst = 1'b1;
    logic [15:0]           bus_addr = 16'h0000;
    logic                  bus_wr = 1'b0;
    logic                  bus_rd = 1'b0;
    logic [7:0]            bus_wdata = 8'h00;
    logic [15:0]           bus_rdata;
    logic                  bus_wait;
    logic                  cmp_ge;
    logic [RES_BITS-1:0]   tap_code;
    logic [CHAN_W-1:0]     analog_mux_sel;
    logic                  sample_hold;
    logic                  reference_boost_enable;
    logic                  comparator_enable;
    logic [7:0]            digital_in_enable;
    logic                  conversion_done_irq;
    logic [8*RES_BITS-1:0] ch_level = {40'h0, 10'h2A5, 10'h3FF, 10'h155, 10'h000};
    int                    num_errors = 0;
    int                    compares = 0;
    int                    cycles = 0;
    int                    n;

    sasp_adc #(.NUM_CH(8)) dut_u (
        .clk(clk), .srst(srst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_wait(bus_wait), .cmp_ge(cmp_ge),
        .tap_code(tap_code), .analog_mux_sel(analog_mux_sel), .sample_hold(sample_hold),
        .reference_boost_enable(reference_boost_enable),
        .comparator_enable(comparator_enable), .digital_in_enable(digital_in_enable),
        .conversion_done_irq(conversion_done_irq)
    );

    sasp_analog_model model_u (
        .clk(clk), .ch_level(ch_level), .analog_mux_sel(analog_mux_sel),
        .sample_hold(sample_hold), .tap_code(tap_code), .cmp_ge(cmp_ge)
    );

    // 10 MHz main clock
    always #50 clk = ~clk;

    // hang guard, generous against the few thousand cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            $display("mismatch run_length expected below 20000 seen 20000");
            conclude();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one-cycle write strobe, wait flag looked at in the cycle after
    task automatic reg_wr(input logic [15:0] addr, input logic [7:0] data, input logic exp_wait);
        @(posedge clk);
        bus_addr  <= addr;
        bus_wdata <= data;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        #1;
        check("bus_wait", {15'h0, bus_wait}, {15'h0, exp_wait});
    endtask : reg_wr

    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [15:0] addr, input logic [15:0] exp, input string what);
        @(posedge clk);
        bus_addr <= addr;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        check(what, bus_rdata, exp);
    endtask : reg_rd

    // cycles until the next done pulse, bounded
    task automatic wait_irq(output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk);
            #1;
            cnt++;
        end while (conversion_done_irq !== 1'b1 && cnt < 1000);
        check("irq_seen", {15'h0, conversion_done_irq}, 16'h0001);
    endtask : wait_irq

    task automatic count_irq(input int span, output int cnt);
        cnt = 0;
        repeat (span)
        begin
            @(posedge clk);
            #1;
            if (conversion_done_irq === 1'b1)
            begin
                cnt++;
            end
        end
    endtask : count_irq

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial
    begin
        static logic [2:0] tcode [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
        static int         tlen  [7] = '{288, 240, 192, 144, 120, 96, 288};
        static logic [7:0] powerfail_mode_reg   [4] = '{8'h80, 8'hC0, 8'h80, 8'hC0};
        static logic [7:0] powerfail_threshold   [4] = '{8'hA9, 8'hA9, 8'hAA, 8'hAA};
        static int         pexp  [4] = '{2, 0, 0, 2};
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        #1;
        check("dig_en", {8'h0, digital_in_enable}, 16'h00FE);
        reg_rd(ADDR_MODE, 16'h0000, "mode_reset");
        reg_rd(ADDR_CHAN, 16'h0000, "chan_reset");
        reg_rd(ADDR_PFM, 16'h0000, "pfm_reset");
        reg_rd(ADDR_PFT, 16'h0000, "pft_reset");
        reg_wr(16'hFF30, 8'hFF, 1'b0);
        reg_rd(16'hFF30, 16'h0000, "unmapped");
        $display("test reset_and_map done");
        // every channel code, and the pin that drops out of digital use
        for (int ch = 0; ch < 8; ch++)
        begin
            reg_wr(ADDR_CHAN, 8'(ch), 1'b1);
            @(posedge clk);
            #1;
            check("mux_sel", {13'h0, analog_mux_sel}, 16'(ch));
            check("dig_en", {8'h0, digital_in_enable}, 16'(8'hFF ^ (8'h01 << ch)));
        end
        reg_wr(ADDR_CHAN, 8'hFB, 1'b1);
        reg_rd(ADDR_CHAN, 16'h0003, "chan_mask");
        reg_wr(ADDR_MODE, 8'h7F, 1'b1);
        reg_rd(ADDR_MODE, 16'h0039, "mode_mask");
        check("boost", {15'h0, reference_boost_enable}, 16'h0001);
        check("cmp_en", {15'h0, comparator_enable}, 16'h0000);
        reg_wr(ADDR_PFM, 8'hFF, 1'b1);
        reg_rd(ADDR_PFM, 16'h00C0, "pfm_mask");
        reg_wr(ADDR_PFT, 8'h5A, 1'b1);
        reg_rd(ADDR_PFT, 16'h005A, "pft_rw");
        reg_wr(ADDR_PFM, 8'h00, 1'b1);
        $display("test registers done");
        // reference first, let it settle, then the six time codes and illegal code 7
        reg_wr(ADDR_MODE, 8'h01, 1'b1);
        repeat (140) @(posedge clk);
        for (int i = 0; i < 7; i++)
        begin
            reg_wr(ADDR_MODE, 8'h01, 1'b1);
            reg_wr(ADDR_CHAN, 8'(i % 4), 1'b1);
            reg_wr(ADDR_MODE, 8'h81 | {2'b00, tcode[i], 3'b000}, 1'b1);
            wait_irq(n);
            wait_irq(n);
            check("conv_len", 16'(n), 16'(tlen[i]));
            reg_rd(ADDR_RESULT, {ch_level[(i % 4)*RES_BITS +: RES_BITS], 6'h00}, "result");
        end
        reg_wr(ADDR_MODE, 8'h01, 1'b1);
        count_irq(400, n);
        check("irq_after_stop", 16'(n), 16'h0000);
        check("cmp_en", {15'h0, comparator_enable}, 16'h0000);
        $display("test conversion done");
        // threshold equal to and one above the result's upper byte, both polarities
        for (int i = 0; i < 4; i++)
        begin
            reg_wr(ADDR_MODE, 8'h00, 1'b1);
            reg_wr(ADDR_CHAN, 8'h03, 1'b1);
            reg_wr(ADDR_PFM, powerfail_mode_reg[i], 1'b1);
            reg_wr(ADDR_PFT, powerfail_threshold[i], 1'b1);
            // 144 cycles keeps the conversion inside the legal time window
            reg_wr(ADDR_MODE, 8'hA0, 1'b1);
            check("boost", {15'h0, reference_boost_enable}, 16'h0000);
            count_irq(320, n);
            check("pf_irqs", 16'(n), 16'(pexp[i]));
        end
        reg_wr(ADDR_MODE, 8'h00, 1'b1);
        $display("test powerfail done");
        conclude();
    end
endmodule : sasp_adc_tb
